//--- zcd_gpo_pkg.sv
// Purpose: Shared constants and types for the zero-cross output update block
// Assumes: Byte-wide registers, one per aligned Avalon word
// Notes: Printed offsets are register indexes; byte address is index times 4
package zcd_gpo_pkg;
	localparam int unsigned NUM_CHAN = 8;
	localparam int unsigned ADDR_W = 10;
	// Register indexes
	localparam logic [7:0] IDX_CODES_LO = 8'he3;
	localparam logic [7:0] IDX_CODES_HI = 8'he4;
	localparam logic [7:0] IDX_ZC_EN = 8'he7;
	localparam logic [7:0] IDX_AL_EN = 8'he9;
	localparam logic [7:0] IDX_AL_VAL = 8'heb;
	localparam logic [7:0] IDX_MASK_BASE = 8'hc3;
	localparam logic [7:0] IDX_OUT_STATE = 8'hf0;
	// Reset values
	localparam logic [7:0] RST_CODES = 8'h00;
	localparam logic [7:0] RST_ZC_EN = 8'h00;
	localparam logic [7:0] RST_AL_EN = 8'h00;
	localparam logic [7:0] RST_AL_VAL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h02;
	localparam logic [7:0] RST_OUT = 8'h00;
	// Field layout of one value code
	localparam int unsigned CODE_W = 2;
	localparam int unsigned CODE_RISE_BIT = 1;
	localparam int unsigned CODE_FALL_BIT = 0;
	localparam int unsigned CODES_PER_BYTE = 4;

	typedef struct packed {
		logic rise;
		logic fall;
	} zc_event_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} av_req_t;
endpackage

//--- mask_mem.sv
// Purpose: Per-output event mask storage, read data registered
// Assumes: One write port, one bus read port, masks also visible flat
// Notes: Flat view feeds the trigger logic directly
`timescale 1ns/1ps
module mask_mem
	import zcd_gpo_pkg::*;
#(
	parameter int unsigned DEPTH = NUM_CHAN
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [2:0] rd_idx,
	output logic [7:0] rd_data,
	// Flat view
	output logic [DEPTH*8-1:0] all_masks
);
	logic [7:0] mem_r [DEPTH];

	initial begin
		if (DEPTH != 8) $error("mask_mem depth must be 8");
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) mem_r[i] <= RST_MASK;
			rd_data <= 8'h00;
		end else begin
			if (wr_en) mem_r[wr_idx] <= wr_data;
			rd_data <= mem_r[rd_idx];
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) all_masks[i*8 +: 8] = mem_r[i];
	end
endmodule

//--- zcd_alert_gpo_update.sv
// Purpose: Event-driven update of eight digital outputs
// Assumes: Zero-cross level and alert flags synchronous to clk_sys
// Notes: Registers reached over Avalon-MM, one wait cycle per access
//
// Overview of operation
// - Each channel has a 2-bit edge code, four channels per byte.
// - Code 00 drives low on both zero-cross edges.
// - Code 01 drives low on rising, high on falling edge.
// - Code 10 drives high on rising, low on falling edge.
// - Code 11 drives high on both zero-cross edges.
// - Zero-cross update enable bit gates edge updates per output.
// - Alert update enable bit allows updates when selected flags rise.
// - With alert enable clear, alert flags never change the output.
// - Alert update sets the output to its alert value bit.
// - Per-output mask selects which input channels' alerts trigger it.
`timescale 1ns/1ps
module zcd_alert_gpo_update
	import zcd_gpo_pkg::*;
#(
	parameter int unsigned CHANNELS = NUM_CHAN
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Event sources
	input wire logic zero_cross_detect,
	input wire logic [CHANNELS-1:0] alert_flags,
	// Digital outputs
	output logic [CHANNELS-1:0] digital_output
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACK = 3'b010,
		ST_DONE = 3'b100
	} bus_state_t;

	initial begin
		if (CHANNELS != 8) $error("block serves exactly 8 channels");
	end

	function automatic logic code_level(input logic [1:0] code,
			input zc_event_t ev);
		code_level = ev.rise ? code[CODE_RISE_BIT] : code[CODE_FALL_BIT];
	endfunction

	function automatic logic idx_is(input logic [ADDR_W-1:0] a,
			input logic [7:0] idx);
		idx_is = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
	endfunction

	bus_state_t state_r, state_nxt;
	av_req_t req;
	logic [7:0] codes_lo_r, codes_hi_r, zc_en_r, al_en_r, al_val_r;
	logic [CHANNELS-1:0] out_r, out_nxt;
	logic zc_prev_r;
	logic [CHANNELS-1:0] alert_prev_r;
	logic [31:0] rdata_r;
	logic [1:0] resp_r;
	logic [CHANNELS*8-1:0] masks;

	assign req = '{address: avs_address, read: avs_read,
		write: avs_write, writedata: avs_writedata};

	// Address decode
	wire logic [7:0] widx = req.address[ADDR_W-1:2];
	wire logic lane0 = avs_byteenable[0];
	wire logic sel_lo = idx_is(req.address, IDX_CODES_LO);
	wire logic sel_hi = idx_is(req.address, IDX_CODES_HI);
	wire logic sel_zc = idx_is(req.address, IDX_ZC_EN);
	wire logic sel_al = idx_is(req.address, IDX_AL_EN);
	wire logic sel_av = idx_is(req.address, IDX_AL_VAL);
	wire logic sel_os = idx_is(req.address, IDX_OUT_STATE);
	wire logic [7:0] mask_off = widx - IDX_MASK_BASE;
	wire logic sel_mk = (req.address[1:0] == 2'b00) && (widx >= IDX_MASK_BASE)
		&& (mask_off <= 8'h0e) && !mask_off[0];
	wire logic [2:0] mask_idx = mask_off[3:1];
	wire logic hit = sel_lo | sel_hi | sel_zc | sel_al | sel_av | sel_os
		| sel_mk;
	wire logic go = (state_r == ST_IDLE) && (req.read || req.write);
	wire logic wr_go = go && req.write && lane0;

	// Bus handshake: decode in idle, answer next cycle, rest one cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (req.read || req.write) state_nxt = ST_ACK;
			end
			ST_ACK: begin
				state_nxt = ST_DONE;
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Read data selection
	wire logic [7:0] rd_byte = sel_lo ? codes_lo_r :
		sel_hi ? codes_hi_r :
		sel_zc ? zc_en_r :
		sel_al ? al_en_r :
		sel_av ? al_val_r :
		sel_os ? out_r :
		sel_mk ? masks[{mask_idx, 3'b000} +: 8] : 8'h00;

	mask_mem #(
		.DEPTH(CHANNELS)
	) u_mask (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr_en(wr_go && sel_mk),
		.wr_idx(mask_idx),
		.wr_data(req.writedata[7:0]),
		.rd_idx(mask_idx),
		.rd_data(),
		.all_masks(masks)
	);

	// Zero-cross edges
	wire logic zc_rise = zero_cross_detect && !zc_prev_r;
	wire logic zc_fall = !zero_cross_detect && zc_prev_r;
	wire zc_event_t zc_ev = '{rise: zc_rise, fall: zc_fall};
	wire logic [7:0] alert_new = alert_flags & ~alert_prev_r;
	wire logic [15:0] all_codes = {codes_hi_r, codes_lo_r};

	// Output update per channel
	always_comb begin
		out_nxt = out_r;
		for (int c = 0; c < CHANNELS; c++) begin
			// Edge code picks the level per edge
			if (zc_en_r[c] && (zc_rise || zc_fall)) begin
				out_nxt[c] = code_level(all_codes[c*CODE_W +: CODE_W],
					zc_ev);
			end
			// Masked alert rising, enabled, wins over zero-cross
			if (al_en_r[c] && |(alert_new & masks[c*8 +: 8])) begin
				out_nxt[c] = al_val_r[c];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			codes_lo_r <= RST_CODES;
			codes_hi_r <= RST_CODES;
			zc_en_r <= RST_ZC_EN;
			al_en_r <= RST_AL_EN;
			al_val_r <= RST_AL_VAL;
			out_r <= RST_OUT;
			zc_prev_r <= 1'b0;
			alert_prev_r <= '0;
		end else begin
			state_r <= state_nxt;
			out_r <= out_nxt;
			zc_prev_r <= zero_cross_detect;
			alert_prev_r <= alert_flags;
			if (wr_go && sel_lo) codes_lo_r <= req.writedata[7:0];
			if (wr_go && sel_hi) codes_hi_r <= req.writedata[7:0];
			if (wr_go && sel_zc) zc_en_r <= req.writedata[7:0];
			if (wr_go && sel_al) al_en_r <= req.writedata[7:0];
			if (wr_go && sel_av) al_val_r <= req.writedata[7:0];
		end
	end

	// Bus answer registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
			resp_r <= 2'b00;
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(state_nxt == ST_ACK);
			if (go) begin
				rdata_r <= {24'h000000, rd_byte};
				resp_r <= hit ? 2'b00 : 2'b11;
			end
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_response = resp_r;
	assign digital_output = out_r;
endmodule

//--- gpo_chk_assertions.sv
// Purpose: Checks at the block ports
// Assumes: Event masks left at reset
// Notes: Enables shadowed from writes
`timescale 1ns/1ps
module gpo_chk import zcd_gpo_pkg::*;
#(parameter int unsigned CHANNELS = NUM_CHAN) (
	// Watched ports
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic zero_cross_detect,
	input wire logic [CHANNELS-1:0] alert_flags,
	input wire logic [CHANNELS-1:0] digital_output
);
	logic z1, z2;
	logic [7:0] a1, a2, q, ze, ae, av;
	wire logic [7:0] d = avs_writedata[7:0];
	wire logic [7:0] ix = avs_address[9:2];
	wire logic [7:0] dl = digital_output ^ q;
	wire logic wr = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire logic zev = z1 != z2;
	wire logic aev = |(a1 & ~a2);
	always_ff @(posedge clk_sys) begin
		{z1, z2, a1} <= {zero_cross_detect, z1, alert_flags};
		{a2, q} <= {a1, digital_output};
		if (!rst_n) {ze, ae, av} <= '0;
		else if (wr && ix == IDX_ZC_EN) ze <= d;
		else if (wr && ix == IDX_AL_EN) ae <= d;
		else if (wr && ix == IDX_AL_VAL) av <= d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_hold; dl != 8'h00 |-> zev || aev; endproperty
	a_hold: assert property (p_hold) else $error("no event");
	property p_zg; zev && !aev |-> (dl & ~ze) == 8'h00; endproperty
	a_zg: assert property (p_zg) else $error("zc gate");
	property p_ag; aev && !zev |-> (dl & ~ae) == 8'h00; endproperty
	a_ag: assert property (p_ag) else $error("alert gate");
	property p_av;
		a1[1] && !a2[1] |-> ((digital_output ^ av) & ae) == 8'h00;
	endproperty
	a_av: assert property (p_av) else $error("alert value");
	property p_w1; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_w1: assert property (p_w1) else $error("wait low");
	property p_an; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
	a_an: assert property (p_an) else $error("no answer");
	property p_up; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 0;
	endproperty
	a_up: assert property (p_up) else $error("upper data");
	property p_rs; $rose(rst_n) |-> digital_output == 8'h00; endproperty
	a_rs: assert property (p_rs) else $error("reset level");
	c_zc: cover property (zev && ze != 8'h00);
	c_al: cover property (aev && ae != 8'h00);
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule
bind zcd_alert_gpo_update gpo_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

//--- gpo_load.sv
// Purpose: Load on the digital outputs
// Assumes: One clock, push-pull pins
// Notes: Level taken each clock
`timescale 1ns/1ps
module gpo_load (
	// Pins and level seen
	input wire logic clk_sys,
	input wire logic [7:0] digital_output,
	output logic [7:0] load_level
);
	always_ff @(posedge clk_sys) load_level <= digital_output;
endmodule

//--- tb_top.sv
// Purpose: Bench for output update
// Assumes: Masks at reset, channel 1 hits all
// Notes: Outputs read back on the bus
`timescale 1ns/1ps
module tb_top import zcd_gpo_pkg::*; ;
	logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0;
	logic zero_cross_detect = 0, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic [3:0] avs_byteenable = 4'hf;
	logic [1:0] avs_response;
	logic [7:0] alert_flags = 0, digital_output, load_level, o = 0, wd[5];
	logic [7:0] wi[5] = '{IDX_CODES_LO, IDX_CODES_HI, IDX_ZC_EN, IDX_AL_EN,
		IDX_AL_VAL};
	logic [15:0] c;
	logic [33:0] e, exp_q[$];
	int error_cnt = 0, num_checks = 0, seed = 32'h3899;
	always #5 clk_sys = ~clk_sys;
	zcd_alert_gpo_update dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response),
		.zero_cross_detect(zero_cross_detect),
		.alert_flags(alert_flags),
		.digital_output(digital_output)
	);
	gpo_load ld (
		.clk_sys(clk_sys),
		.digital_output(digital_output),
		.load_level(load_level)
	);
	task automatic chk(logic [33:0] s, x);
		num_checks++;
		if (s !== x) error_cnt++;
		if (s !== x) $display("BAD %0t mismatch %h %h", $time, s, x);
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic acc(logic w, logic [7:0] i, d, logic [33:0] x);
		int n = 0;
		if (!w) exp_q.push_back(x);
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h0, d};
		{avs_write, avs_read} <= {w, !w};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0 && ++n < 20);
		{avs_write, avs_read} <= 2'b00;
		if (n == 20) error_cnt++;
		if (n == 20) stop_test();
		@(posedge clk_sys);
	endtask
	task automatic ev(logic z, logic [7:0] f);
		if (z != zero_cross_detect)
			for (int i = 0; i < 8; i++) if (wd[2][i]) o[i] = c[2*i+z];
		if (f[1] && !alert_flags[1]) o = o & ~wd[3] | wd[4] & wd[3];
		{zero_cross_detect, alert_flags} <= {z, f};
		@(posedge clk_sys);
		acc(0, IDX_OUT_STATE, 0, {26'h0, o});
	endtask
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			e = exp_q.pop_front();
			chk({avs_response, avs_readdata}, e);
			if (avs_address[9:2] == IDX_OUT_STATE)
				chk({26'h0, load_level}, e);
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1;
		@(posedge clk_sys);
		foreach (wi[k]) acc(0, wi[k], 0, 34'h0);
		acc(0, IDX_MASK_BASE, 0, 34'h2);
		acc(0, 8'h10, 0, 34'h3_0000_0000);
		repeat (8) begin
			foreach (wd[k]) wd[k] = 8'($random(seed));
			c = {wd[1], wd[0]};
			foreach (wi[k]) acc(1, wi[k], wd[k], 0);
			ev(1, 8'h00);
			ev(1, 8'h02);
			ev(1, 8'h03);
			ev(1, 8'h00);
			ev(0, 8'h02);
		end
		avs_byteenable <= 4'he;
		acc(1, IDX_ZC_EN, ~wd[2], 0);
		avs_byteenable <= 4'hf;
		acc(0, IDX_ZC_EN, 0, {26'h0, wd[2]});
		stop_test();
	end
endmodule
